// *** logic/cmpc_route.sv ***
// cmpc_route: input routing and the two comparators, unsynchronized
`timescale 1ns/1ps
`default_nettype none

module cmpc_route (
    input wire cmpc_pkg::cmpc_mode_t mode,
    input wire logic input_switch,
    input wire logic [1:0] invert,
    input wire cmpc_pkg::cmpc_analog_t lvl,
    output logic [1:0] cmp_raw
);
    logic [7:0] pos1;
    logic [7:0] neg1;
    logic [7:0] pos2;
    logic [7:0] neg2;
    logic [1:0] on;

    always_comb begin
        pos1 = lvl.pin2;
        neg1 = lvl.pin0;
        pos2 = lvl.pin2;
        neg2 = lvl.pin1;
        on = 2'h3;
        unique case (mode)
            cmpc_pkg::CMPC_MODE_RESET,
            cmpc_pkg::CMPC_MODE_OFF: begin
                on = 2'h0;
            end
            cmpc_pkg::CMPC_MODE_MUX3: begin
                neg1 = input_switch ? lvl.pin3 : lvl.pin0;
            end
            cmpc_pkg::CMPC_MODE_VREF: begin
                pos1 = lvl.vref;
                pos2 = lvl.vref;
                neg1 = input_switch ? lvl.pin3 : lvl.pin0;
                neg2 = input_switch ? lvl.pin2 : lvl.pin1;
            end
            cmpc_pkg::CMPC_MODE_COMREF,
            cmpc_pkg::CMPC_MODE_COMREF_OUT: begin
                pos1 = lvl.pin2;
                neg1 = lvl.pin0;
                pos2 = lvl.pin2;
                neg2 = lvl.pin1;
            end
            cmpc_pkg::CMPC_MODE_INDEP2: begin
                pos1 = lvl.pin3;
            end
            cmpc_pkg::CMPC_MODE_INDEP1: begin
                on = 2'h2;
            end
        endcase
        // equal levels read low, or high when inverted; a powered-down comparator reads low
        cmp_raw[0] = on[0] & ((pos1 > neg1) ^ invert[0]);
        cmp_raw[1] = on[1] & ((pos2 > neg2) ^ invert[1]);
    end

endmodule

`default_nettype wire

// *** logic/cmpc_top.sv ***
// cmpc_top: dual comparator control with an AXI4-Lite register slave
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "cmpc_defs.svh"

module cmpc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire cmpc_pkg::cmpc_analog_t analog_level,
    output logic port_a_pin3_out,
    output logic port_a_pin3_oe,
    output logic port_a_pin4_out,
    output logic port_a_pin4_oe,
    output logic comparator_change_flag,
    output logic comparator_change_enable
);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [8:0] SETTLE_CYC = 9'(`CMPC_SETTLE_CYC);
    // register state
    cmpc_pkg::cmpc_ctrl_t ctrl, next_ctrl;
    logic [7:0] port_a_direction, next_port_a_direction;
    logic next_flag, next_enable;
    logic [1:0] last_out, next_last_out;
    logic [8:0] settle_cnt, next_settle_cnt;
    // comparator outputs and their synchroniser
    logic [1:0] cmp_raw, sync1, sync2, sync3, cmp_out, next_cmp_out;
    logic mismatch;
    // bus state
    logic aw_hold, next_aw_hold, w_hold, next_w_hold, w_lane0, next_w_lane0;
    logic [5:0] aw_idx, next_aw_idx, ar_idx;
    logic [7:0] w_byte, next_w_byte, ctrl_view;
    logic next_bvalid, next_rvalid, wr_fire, rd_fire, wr_ctrl, rd_ctrl;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    cmpc_route u_route (
        .mode(ctrl.mode),
        .input_switch(ctrl.input_switch),
        .invert({ctrl.inv2, ctrl.inv1}),
        .lvl(analog_level),
        .cmp_raw(cmp_raw)
    );

    // comparator results are asynchronous to aclk; count a change once stages 2 and 3 agree
    always_comb begin
        next_cmp_out = cmp_out;
        for (int i = 0; i < 2; i++) begin
            if (sync2[i] == sync3[i]) begin
                next_cmp_out[i] = sync3[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= 2'h0;
            sync2 <= 2'h0;
            sync3 <= 2'h0;
            cmp_out <= 2'h0;
        end else begin
            sync1 <= cmp_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            cmp_out <= next_cmp_out;
        end
    end

    // bus handshakes
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign ar_idx = s_axi_araddr[7:2];
    assign wr_ctrl = wr_fire && (aw_idx == `CMPC_CTRL_IDX) && w_lane0;
    assign rd_ctrl = rd_fire && (ar_idx == `CMPC_CTRL_IDX);
    assign mismatch = (cmp_out != last_out);

    always_comb begin
        ctrl_view = ctrl;
        ctrl_view[`CMPC_OUT2_BIT] = cmp_out[1];
        ctrl_view[`CMPC_OUT1_BIT] = cmp_out[0];
    end

    always_comb begin
        next_aw_hold = aw_hold;
        next_aw_idx = aw_idx;
        next_w_hold = w_hold;
        next_w_byte = w_byte;
        next_w_lane0 = w_lane0;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_hold = 1'b1;
            next_aw_idx = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_hold = 1'b1;
            next_w_byte = s_axi_wdata[7:0];
            next_w_lane0 = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            next_aw_hold = 1'b0;
            next_w_hold = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            if (aw_idx != `CMPC_CTRL_IDX && aw_idx != `CMPC_DIR_IDX &&
                aw_idx != `CMPC_FLAG_IDX) begin
                next_bresp = RESP_SLVERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h0;
            unique case (ar_idx)
                `CMPC_CTRL_IDX: next_rdata[7:0] = ctrl_view;
                `CMPC_DIR_IDX: next_rdata[7:0] = port_a_direction;
                `CMPC_FLAG_IDX: begin
                    next_rdata[`CMPC_FLAG_BIT] = comparator_change_flag;
                    next_rdata[`CMPC_EN_BIT] = comparator_change_enable;
                    next_rdata[`CMPC_SETTLE_BIT] = (settle_cnt != 9'h0);
                end
                default: next_rresp = RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            aw_idx <= 6'h0;
            w_hold <= 1'b0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else begin
            aw_hold <= next_aw_hold;
            aw_idx <= next_aw_idx;
            w_hold <= next_w_hold;
            w_byte <= next_w_byte;
            w_lane0 <= next_w_lane0;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // registers, change detection and settling
    always_comb begin
        next_ctrl = ctrl;
        next_port_a_direction = port_a_direction;
        next_flag = comparator_change_flag;
        next_enable = comparator_change_enable;
        next_last_out = last_out;
        next_settle_cnt = (settle_cnt != 9'h0) ? settle_cnt - 9'h1 : 9'h0;
        if (wr_ctrl) begin
            next_ctrl.mode = cmpc_pkg::cmpc_mode_t'(w_byte[2:0]);
            next_ctrl.input_switch = w_byte[`CMPC_SW_BIT];
            next_ctrl.inv1 = w_byte[`CMPC_INV1_BIT];
            next_ctrl.inv2 = w_byte[`CMPC_INV2_BIT];
            if (w_byte[2:0] != ctrl.mode) begin
                next_settle_cnt = SETTLE_CYC;
            end
        end
        if (wr_fire && aw_idx == `CMPC_DIR_IDX && w_lane0) begin
            next_port_a_direction = w_byte;
        end
        if (wr_fire && aw_idx == `CMPC_FLAG_IDX && w_lane0) begin
            // writing a one raises a simulated change event
            next_flag = w_byte[`CMPC_FLAG_BIT];
            next_enable = w_byte[`CMPC_EN_BIT];
        end
        // a read, or a write with byte lane 0 strobed, of the control register ends the mismatch
        if (rd_ctrl || wr_ctrl) begin
            next_last_out = cmp_out;
        end
        // set wins over a clear in the same cycle
        if (mismatch) begin
            next_flag = 1'b1;
        end
        next_ctrl.out1 = 1'b0;
        next_ctrl.out2 = 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= cmpc_pkg::cmpc_ctrl_t'(`CMPC_CTRL_RST);
            port_a_direction <= `CMPC_DIR_RST;
            comparator_change_flag <= 1'b0;
            comparator_change_enable <= 1'b0;
            last_out <= 2'h0;
            settle_cnt <= 9'h0;
        end else begin
            ctrl <= next_ctrl;
            port_a_direction <= next_port_a_direction;
            comparator_change_flag <= next_flag;
            comparator_change_enable <= next_enable;
            last_out <= next_last_out;
            settle_cnt <= next_settle_cnt;
        end
    end

    // pin output path bypasses the synchroniser by design; pins stay inputs when direction is 1
    always_comb begin
        port_a_pin3_oe = (ctrl.mode == cmpc_pkg::CMPC_MODE_COMREF_OUT) &&
            !port_a_direction[`CMPC_DIR_PIN3];
        port_a_pin4_oe = (ctrl.mode == cmpc_pkg::CMPC_MODE_COMREF_OUT) &&
            !port_a_direction[`CMPC_DIR_PIN4];
        port_a_pin3_out = port_a_pin3_oe & cmp_raw[0];
        port_a_pin4_out = port_a_pin4_oe & cmp_raw[1];
    end

    flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mismatch |=> comparator_change_flag)
        else $error("change flag not set on mismatch");

    reset_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> (ctrl.mode == cmpc_pkg::CMPC_MODE_RESET) && !comparator_change_flag)
        else $error("mode field not reset");

    read_ends_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_ctrl |=> (last_out == $past(cmp_out)))
        else $error("control read did not end mismatch");
    mode_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_ctrl |=> (ctrl.mode == $past(w_byte[2:0])) && s_axi_bvalid)
        else $error("mode field not written");
    report_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_ctrl |=> s_axi_rvalid && (s_axi_rdata[7:6] == $past(cmp_out)))
        else $error("reported outputs wrong");

    pin_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl.mode == cmpc_pkg::CMPC_MODE_COMREF_OUT) && !port_a_direction[`CMPC_DIR_PIN3]
        |-> port_a_pin3_oe && (port_a_pin3_out == cmp_raw[0]))
        else $error("pin 3 not driven in output mode");

    pin_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (port_a_direction[`CMPC_DIR_PIN4] || ctrl.mode != cmpc_pkg::CMPC_MODE_COMREF_OUT)
        |-> !port_a_pin4_oe && !port_a_pin4_out)
        else $error("pin 4 driven against direction");

    settle_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(ctrl.mode) |-> (settle_cnt == SETTLE_CYC) ##1 (settle_cnt == SETTLE_CYC - 9'h1))
        else $error("settle counter not loaded on mode change");

endmodule

`default_nettype wire

// *** pkg/cmpc_defs.svh ***
// cmpc_defs.svh: offsets, field positions, reset values and timing of the comparator control
`ifndef CMPC_DEFS_SVH
`define CMPC_DEFS_SVH

// register indices; byte address is four times the index
`define CMPC_CTRL_IDX 8'h1F
`define CMPC_DIR_IDX 8'h20
`define CMPC_FLAG_IDX 8'h21

// reset values
`define CMPC_CTRL_RST 8'h00
`define CMPC_DIR_RST 8'hFF

// comparator_control field positions
`define CMPC_MODE_LSB 0
`define CMPC_SW_BIT 3
`define CMPC_INV1_BIT 4
`define CMPC_INV2_BIT 5
`define CMPC_OUT1_BIT 6
`define CMPC_OUT2_BIT 7

// change register field positions
`define CMPC_FLAG_BIT 0
`define CMPC_EN_BIT 1
`define CMPC_SETTLE_BIT 2

// port_a_direction bits of the output pins
`define CMPC_DIR_PIN3 3
`define CMPC_DIR_PIN4 4

// timing
`define CMPC_CLK_MHZ 40
`define CMPC_SETTLE_NS 10000
`define CMPC_SETTLE_CYC ((`CMPC_SETTLE_NS * `CMPC_CLK_MHZ + 999) / 1000)

`endif

// *** pkg/cmpc_pkg.sv ***
// cmpc_pkg: types of the comparator control
package cmpc_pkg;

    typedef enum logic [2:0] {
        CMPC_MODE_RESET = 3'h0,
        CMPC_MODE_MUX3 = 3'h1,
        CMPC_MODE_VREF = 3'h2,
        CMPC_MODE_COMREF = 3'h3,
        CMPC_MODE_INDEP2 = 3'h4,
        CMPC_MODE_INDEP1 = 3'h5,
        CMPC_MODE_COMREF_OUT = 3'h6,
        CMPC_MODE_OFF = 3'h7
    } cmpc_mode_t;

    typedef struct packed {
        logic [7:0] vref;
        logic [7:0] pin3;
        logic [7:0] pin2;
        logic [7:0] pin1;
        logic [7:0] pin0;
    } cmpc_analog_t;

    typedef struct packed {
        logic out2;
        logic out1;
        logic inv2;
        logic inv1;
        logic input_switch;
        cmpc_mode_t mode;
    } cmpc_ctrl_t;

endpackage

// *** testbench/tb_dual_comparator_control.sv ***
// tb_dual_comparator_control: self-checking bench for the dual comparator control block
`timescale 1ns/1ps
`default_nettype none
`include "cmpc_defs.svh"

module tb_dual_comparator_control;
    localparam logic [7:0] ADDR_CTRL = 8'(`CMPC_CTRL_IDX << 2);
    localparam logic [7:0] ADDR_DIR = 8'(`CMPC_DIR_IDX << 2);
    localparam logic [7:0] ADDR_CHG = 8'(`CMPC_FLAG_IDX << 2);
    localparam logic [7:0] ADDR_NONE = 8'h88;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    cmpc_pkg::cmpc_analog_t analog_level = '0;
    logic port_a_pin3_out, port_a_pin3_oe, port_a_pin4_out, port_a_pin4_oe;
    logic comparator_change_flag, comparator_change_enable;
    int error_cnt = 0;
    int num_checks = 0;

    cmpc_top u_cmpc_top (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .analog_level(analog_level),
        .port_a_pin3_out(port_a_pin3_out), .port_a_pin3_oe(port_a_pin3_oe),
        .port_a_pin4_out(port_a_pin4_out), .port_a_pin4_oe(port_a_pin4_oe),
        .comparator_change_flag(comparator_change_flag),
        .comparator_change_enable(comparator_change_enable)
    );

    always #12.5 aclk = ~aclk;

    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic hang(input string msg);
        error_cnt++;
        $display("wrong value at %0t: %s no answer", $time, msg);
        end_of_test();
    endtask

    // {out2, out1} as the mode table routes the inputs; equal levels give low, or high when inverted
    function automatic logic [1:0] exp_out(input logic [2:0] m, input logic sw,
                                           input logic [1:0] inv, input cmpc_pkg::cmpc_analog_t a);
        logic c1;
        logic c2;
        logic [1:0] pw;
        c1 = a.pin2 > (sw ? a.pin3 : a.pin0);
        c2 = a.pin2 > a.pin1;
        pw = 2'b11;
        case (m)
            3'h0, 3'h7: pw = 2'b00;
            3'h2: begin
                c1 = a.vref > (sw ? a.pin3 : a.pin0);
                c2 = a.vref > (sw ? a.pin2 : a.pin1);
            end
            3'h3, 3'h6: c1 = a.pin2 > a.pin0;
            3'h4: c1 = a.pin3 > a.pin0;
            3'h5: pw = 2'b10;
            default: ;
        endcase
        return ({c2, c1} ^ inv) & pw;
    endfunction

    // address and data offered together, each dropped once taken
    task automatic wr_chk(input logic [7:0] addr, input logic [31:0] data, input logic [3:0] strb,
                          input logic [1:0] resp, input string msg);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= addr;
        s_axi_wdata <= data;
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        if (n >= 50) hang(msg);
        check(32'(s_axi_bresp), 32'(resp), msg);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input logic [31:0] mask,
                          input logic [1:0] resp, input string msg);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        if (n >= 50) hang(msg);
        check(s_axi_rdata & mask, exp, msg);
        check(32'(s_axi_rresp), 32'(resp), msg);
    endtask

    initial begin
        cmpc_pkg::cmpc_analog_t a;
        logic [7:0] cv;
        logic [1:0] ex;
        int seed;
        seed = $urandom(29156);
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(ADDR_CTRL, 32'h0000_0000, 32'hFF, 2'b00, "ctrl reset");
        rd_chk(ADDR_DIR, 32'h0000_00FF, 32'hFF, 2'b00, "dir reset");
        rd_chk(ADDR_CHG, 32'h0000_0000, 32'hFF, 2'b00, "chg reset");
        wr_chk(ADDR_CTRL, 32'h0000_00C0, 4'h1, 2'b00, "ro write");
        rd_chk(ADDR_CTRL, 32'h0000_0000, 32'hFFFF_FFFF, 2'b00, "ro bits");
        wr_chk(ADDR_CTRL, 32'h0000_0007, 4'h0, 2'b00, "no strobe");
        rd_chk(ADDR_CTRL, 32'h0000_0000, 32'hFF, 2'b00, "no strobe");
        wr_chk(ADDR_NONE, 32'h0000_005A, 4'hF, 2'b10, "unmapped wr");
        rd_chk(ADDR_NONE, 32'h0000_0000, 32'hFFFF_FFFF, 2'b10, "unmapped rd");
        $display("test registers done");
        // every mode three times, with ties and extremes among the random levels
        for (int i = 0; i < 24; i++) begin
            a = {8'($urandom), 32'($urandom)};
            if (i == 3) a = {5{8'h80}};
            if (i == 18) a = {8'hFF, 32'h0000_0000};
            cv = {2'b00, 2'($urandom), 1'($urandom), 3'(i % 8)};
            @(posedge aclk);
            analog_level <= a;
            wr_chk(ADDR_CTRL, {24'h0, cv}, 4'h1, 2'b00, "mode write");
            repeat (`CMPC_SETTLE_CYC + 8) @(posedge aclk);
            ex = exp_out(cv[2:0], cv[3], cv[5:4], a);
            rd_chk(ADDR_CTRL, {24'h0, ex, cv[5:0]}, 32'hFF, 2'b00, "outputs");
        end
        $display("test modes done");
        a = {8'h40, 8'h10, 8'h80, 8'hF0, 8'h20};
        @(posedge aclk);
        analog_level <= a;
        wr_chk(ADDR_DIR, 32'h0000_0000, 4'h1, 2'b00, "dir out");
        for (int k = 0; k < 2; k++) begin
            cv = (k == 0) ? 8'h06 : 8'h36;
            wr_chk(ADDR_CTRL, {24'h0, cv}, 4'h1, 2'b00, "pin mode");
            @(posedge aclk);
            ex = exp_out(cv[2:0], cv[3], cv[5:4], a);
            check(32'({port_a_pin4_oe, port_a_pin3_oe}), 32'h3, "pin oe");
            check(32'({port_a_pin4_out, port_a_pin3_out}), 32'(ex), "pin out");
        end
        wr_chk(ADDR_DIR, 32'h0000_0010, 4'h1, 2'b00, "pin4 input");
        @(posedge aclk);
        check(32'({port_a_pin4_oe, port_a_pin3_oe}), 32'h1, "pin oe dir");
        wr_chk(ADDR_CTRL, 32'h0000_0003, 4'h1, 2'b00, "leave pin mode");
        rd_chk(ADDR_CHG, 32'h0000_0004, 32'h4, 2'b00, "settling");
        check(32'({port_a_pin4_oe, port_a_pin3_oe}), 32'h0, "pin off");
        repeat (410) @(posedge aclk);
        rd_chk(ADDR_CHG, 32'h0000_0000, 32'h4, 2'b00, "settled");
        $display("test pins done");
        wr_chk(ADDR_CHG, 32'h0000_0000, 4'h1, 2'b00, "mask");
        rd_chk(ADDR_CTRL, 32'h0000_0043, 32'hFF, 2'b00, "end change");
        wr_chk(ADDR_CHG, 32'h0000_0002, 4'h1, 2'b00, "clear flag");
        rd_chk(ADDR_CHG, 32'h0000_0002, 32'hFF, 2'b00, "flag clear");
        check(32'(comparator_change_enable), 32'h1, "enable port");
        a.pin0 = 8'hFF;
        @(posedge aclk);
        analog_level <= a;
        repeat (8) @(posedge aclk);
        check(32'(comparator_change_flag), 32'h1, "flag set");
        wr_chk(ADDR_CHG, 32'h0000_0002, 4'h1, 2'b00, "clear early");
        check(32'(comparator_change_flag), 32'h1, "mismatch holds");
        rd_chk(ADDR_CTRL, 32'h0000_0003, 32'hFF, 2'b00, "read ends");
        wr_chk(ADDR_CHG, 32'h0000_0000, 4'h1, 2'b00, "clear late");
        check(32'(comparator_change_flag), 32'h0, "flag cleared");
        wr_chk(ADDR_CHG, 32'h0000_0001, 4'h1, 2'b00, "flag write");
        check(32'(comparator_change_flag), 32'h1, "flag forced");
        $display("test flag done");
        end_of_test();
    end
endmodule
`default_nettype wire
